/* File: hw/clk_glitchfree_mux.sv */
// Glitch-free source switch: drop old enable, wait, raise new enable
`timescale 1ns/100ps
`default_nettype none
module clk_glitchfree_mux (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] src_tick,
   clk_switch_if.sw sw,
   output logic sys_tick
);
   logic [1:0] active_ff;
   logic gate_ff;
   logic [1:0] gap_ff;

   // Ticks are whole one-cycle pulses, so the old gate may drop at once;
   // waiting for a tick of a dead source would hang the failover
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         active_ff <= 2'h0;
         gate_ff <= 1'b1;
         gap_ff <= 2'h0;
      end else if (gate_ff && sw.want_src != active_ff) begin
         gate_ff <= 1'b0;
         gap_ff <= 2'h3;
      end else if (!gate_ff) begin
         if (gap_ff != 2'h0) begin
            gap_ff <= gap_ff - 2'h1;
         end else if (src_tick[sw.want_src]) begin
            active_ff <= sw.want_src;
            gate_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sys_tick <= 1'b0;
      end else begin
         sys_tick <= gate_ff && src_tick[active_ff];
      end
   end

   assign sw.cur_src = active_ff;
   assign sw.busy = !gate_ff || (sw.want_src != active_ff);
endmodule : clk_glitchfree_mux
`default_nettype wire

/* File: hw/clk_switch_if.sv */
// Handshake between control logic and the glitch-free clock switch
`timescale 1ns/100ps
`default_nettype none
interface clk_switch_if;
   logic [1:0] want_src;
   logic [1:0] cur_src;
   logic busy;
   modport ctrl (output want_src, input cur_src, input busy);
   modport sw (input want_src, output cur_src, output busy);
endinterface : clk_switch_if
`default_nettype wire

/* File: hw/osc_ctl.sv */
// Oscillator control: locked control register, source select, failure detection
// How it works
// - Pick internal fast/slow, external or watchdog
// - Unlock by E7h then 18h writes
// - Next write updates register, then relocks
// - Other write sequences leave register unchanged
// - Writes to other addresses may fall between the unlock keys
// - Detectors may be re-enabled after switch
// - Internal oscillator stays on until disabled
// - Primary failure: event, switch to watchdog
// - No switch if watchdog off or selected
// - Primary fails below about 1 kHz
// - Watchdog failure: event only, no switch
// - After watchdog failure, primary detection stops
// - Watchdog fails after 8004 clocks without edge
// - Selected clock off and no primary detection halts
// - Register bit layout, bit 6 reserved
// - Reset sets both oscillator enables only
`timescale 1ns/100ps
`default_nettype none
module osc_ctl
   import osc_ctl_pkg::*;
#(
   parameter int PRIM_FAIL_LIMIT = PRIM_FAIL_CYCLES,
   parameter int WDOG_HUNT_LIMIT = WDOG_HUNT_CYCLES
) (
   input wire logic CLK_SYS,
   input wire logic RESET,
   input wire logic [11:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   input wire logic INT_FAST_TICK,
   input wire logic INT_SLOW_TICK,
   input wire logic EXT_CLOCK_PIN,
   input wire logic WDOG_OSC_TICK,
   output logic SYS_CLK_TICK,
   output logic INTERNAL_OSC_ENABLE,
   output logic WDOG_OSC_ENABLE,
   output logic PRIM_FAIL_EVENT,
   output logic WDOG_FAIL_EVENT,
   output logic [2:0] ACTIVE_SOURCE,
   output logic HALTED
);
   // Counters are 20 and 14 bits wide
   if (PRIM_FAIL_LIMIT < 2 || PRIM_FAIL_LIMIT > 1048575) begin : g_bad_prim_limit
      $error("PRIM_FAIL_LIMIT out of range");
   end
   if (WDOG_HUNT_LIMIT < 2 || WDOG_HUNT_LIMIT > 16383) begin : g_bad_hunt_limit
      $error("WDOG_HUNT_LIMIT out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers and edge detect
   logic [1:0] ext_sync_ff;
   logic [1:0] wdog_sync_ff;
   logic ext_last_ff;
   logic wdog_last_ff;
   logic ext_tick;
   logic wdog_edge;

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         ext_sync_ff <= 2'h0;
         wdog_sync_ff <= 2'h0;
         ext_last_ff <= 1'b0;
         wdog_last_ff <= 1'b0;
      end else begin
         ext_sync_ff <= {ext_sync_ff[0], EXT_CLOCK_PIN};
         wdog_sync_ff <= {wdog_sync_ff[0], WDOG_OSC_TICK};
         ext_last_ff <= ext_sync_ff[1];
         wdog_last_ff <= wdog_sync_ff[1];
      end
   end

   assign ext_tick = ext_sync_ff[1] && !ext_last_ff;
   assign wdog_edge = wdog_sync_ff[1] && !wdog_last_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Control register and lock sequencer
   logic [7:0] oscillator_control_reg_ff;
   lock_state_t lock_ff;
   lock_state_t nxt_lock;
   logic ctl_wr;
   logic ctl_update;

   assign ctl_wr = WR && (ADDR == OSC_CTL_ADDR);
   assign ctl_update = ctl_wr && (lock_ff == LOCK_OPEN);

   // Only writes to this address move the sequencer; other traffic is ignored
   always_comb begin
      nxt_lock = lock_ff;
      if (ctl_wr) begin
         case (lock_ff)
            LOCK_IDLE: nxt_lock = (WDATA == UNLOCK_KEY_FIRST) ? LOCK_GOT_FIRST : LOCK_IDLE;
            LOCK_GOT_FIRST: begin
               if (WDATA == UNLOCK_KEY_SECOND) begin
                  nxt_lock = LOCK_OPEN;
               end else if (WDATA == UNLOCK_KEY_FIRST) begin
                  nxt_lock = LOCK_GOT_FIRST;
               end else begin
                  nxt_lock = LOCK_IDLE;
               end
            end
            LOCK_OPEN: nxt_lock = LOCK_IDLE;
            default: nxt_lock = LOCK_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         lock_ff <= LOCK_IDLE;
      end else begin
         lock_ff <= nxt_lock;
      end
   end

   logic prim_fail_ff;
   logic recover_ff;

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         oscillator_control_reg_ff <= OSC_CTL_RESET;
      end else if (ctl_update) begin
         oscillator_control_reg_ff <= WDATA;
         oscillator_control_reg_ff[RSVD_BIT] <= 1'b0;
      end
   end

   logic internal_osc_enable;
   logic wdog_osc_enable;
   logic primary_fail_detect_enable;
   logic wdog_osc_fail_detect_enable;
   logic [2:0] clock_source_select;

   assign internal_osc_enable = oscillator_control_reg_ff[INT_OSC_EN_BIT];
   assign wdog_osc_enable = oscillator_control_reg_ff[WDOG_OSC_EN_BIT];
   assign primary_fail_detect_enable = oscillator_control_reg_ff[PRIM_FAIL_EN_BIT];
   assign wdog_osc_fail_detect_enable = oscillator_control_reg_ff[WDOG_FAIL_EN_BIT];
   assign clock_source_select = oscillator_control_reg_ff[SEL_LSB +: SEL_W];

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         RDATA <= 8'h00;
      end else if (RD && ADDR == OSC_CTL_ADDR) begin
         RDATA <= oscillator_control_reg_ff;
      end else begin
         RDATA <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Source selection through glitch-free switch
   function automatic logic [1:0] src_index(input logic [2:0] sel);
      case (sel)
         SEL_INT_FAST: src_index = 2'h0;
         SEL_INT_SLOW: src_index = 2'h1;
         SEL_EXT: src_index = 2'h2;
         SEL_WDOG: src_index = 2'h3;
         default: src_index = 2'h0;
      endcase
   endfunction : src_index

   clk_switch_if sw_if ();
   logic [3:0] src_tick;
   logic sys_tick;

   // Disabled oscillators produce no ticks
   assign src_tick = {wdog_edge && wdog_osc_enable, ext_tick,
                      INT_SLOW_TICK && internal_osc_enable, INT_FAST_TICK && internal_osc_enable};
   assign sw_if.want_src = recover_ff ? 2'h3 : src_index(clock_source_select);

   clk_glitchfree_mux u_mux (
      .clk(CLK_SYS),
      .rst(RESET),
      .src_tick(src_tick),
      .sw(sw_if.sw),
      .sys_tick(sys_tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Primary oscillator failure: no system tick for 1 ms
   logic [19:0] prim_cnt_ff;
   logic wdog_fail_ff;
   logic prim_armed;

   // Detector idle while the switch is busy, since the gap is not a failure
   assign prim_armed = primary_fail_detect_enable && !wdog_fail_ff && !prim_fail_ff && !sw_if.busy;

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         prim_cnt_ff <= 20'h00000;
      end else if (!prim_armed || sys_tick) begin
         prim_cnt_ff <= 20'h00000;
      end else if (prim_cnt_ff != 20'(PRIM_FAIL_LIMIT)) begin
         prim_cnt_ff <= prim_cnt_ff + 20'h00001;
      end
   end

   // Fault latched until the next unlocked register write
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         prim_fail_ff <= 1'b0;
         recover_ff <= 1'b0;
      end else if (prim_armed && prim_cnt_ff == 20'(PRIM_FAIL_LIMIT - 1) && !sys_tick) begin
         prim_fail_ff <= 1'b1;
         recover_ff <= wdog_osc_enable && (clock_source_select != SEL_WDOG);
      end else if (ctl_update) begin
         prim_fail_ff <= 1'b0;
         recover_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog oscillator failure: count system clocks between watchdog edges
   logic [13:0] wdog_cnt_ff;
   logic wdog_armed;

   assign wdog_armed = wdog_osc_fail_detect_enable && !wdog_fail_ff;

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         wdog_cnt_ff <= 14'h0000;
      end else if (!wdog_armed || wdog_edge) begin
         wdog_cnt_ff <= 14'h0000;
      end else if (sys_tick) begin
         wdog_cnt_ff <= wdog_cnt_ff + 14'h0001;
      end
   end

   // No source change here, only the event
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         wdog_fail_ff <= 1'b0;
      end else if (wdog_armed && sys_tick && !wdog_edge && wdog_cnt_ff == 14'(WDOG_HUNT_LIMIT - 1)) begin
         wdog_fail_ff <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   logic prim_fail_q_ff;
   logic wdog_fail_q_ff;

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         SYS_CLK_TICK <= 1'b0;
         INTERNAL_OSC_ENABLE <= 1'b1;
         WDOG_OSC_ENABLE <= 1'b1;
         ACTIVE_SOURCE <= SEL_INT_FAST;
         prim_fail_q_ff <= 1'b0;
         wdog_fail_q_ff <= 1'b0;
         PRIM_FAIL_EVENT <= 1'b0;
         WDOG_FAIL_EVENT <= 1'b0;
         HALTED <= 1'b0;
      end else begin
         SYS_CLK_TICK <= sys_tick;
         INTERNAL_OSC_ENABLE <= internal_osc_enable;
         WDOG_OSC_ENABLE <= wdog_osc_enable;
         ACTIVE_SOURCE <= {1'b0, sw_if.cur_src};
         prim_fail_q_ff <= prim_fail_ff;
         wdog_fail_q_ff <= wdog_fail_ff;
         PRIM_FAIL_EVENT <= prim_fail_ff && !prim_fail_q_ff;
         WDOG_FAIL_EVENT <= wdog_fail_ff && !wdog_fail_q_ff;
         // Selected source switched off with primary detection off: only power-on reset helps
         HALTED <= !primary_fail_detect_enable && !recover_ff &&
                   ((src_index(clock_source_select) < 2'h2 && !internal_osc_enable) ||
                    (clock_source_select == SEL_WDOG && !wdog_osc_enable));
      end
   end
endmodule : osc_ctl
`default_nettype wire

/* File: hw/osc_ctl_pkg.sv */
// Constants and types shared by the oscillator control block
package osc_ctl_pkg;
   // Register address of the oscillator control register
   localparam logic [11:0] OSC_CTL_ADDR = 12'hf86;
   // Unlock key values, in order
   localparam logic [7:0] UNLOCK_KEY_FIRST = 8'he7;
   localparam logic [7:0] UNLOCK_KEY_SECOND = 8'h18;
   // Field positions
   localparam int INT_OSC_EN_BIT = 7;
   localparam int RSVD_BIT = 6;
   localparam int WDOG_OSC_EN_BIT = 5;
   localparam int PRIM_FAIL_EN_BIT = 4;
   localparam int WDOG_FAIL_EN_BIT = 3;
   localparam int SEL_LSB = 0;
   localparam int SEL_W = 3;
   localparam logic [7:0] OSC_CTL_RESET = 8'ha0;
   // Source select encoding
   localparam logic [2:0] SEL_INT_FAST = 3'h0;
   localparam logic [2:0] SEL_INT_SLOW = 3'h1;
   localparam logic [2:0] SEL_EXT = 3'h2;
   localparam logic [2:0] SEL_WDOG = 3'h3;
   // Nominal oscillator rates in Hz
   localparam int INT_FAST_HZ = 5530000;
   localparam int INT_SLOW_HZ = 32800;
   // Watchdog clock hunt limit in system clocks
   localparam int WDOG_HUNT_CYCLES = 8004;
   // Primary failure threshold: 1 kHz
   localparam int PRIM_FAIL_HZ = 1000;
   localparam int CLK_SYS_HZ = 100000000;
   localparam int PRIM_FAIL_CYCLES = CLK_SYS_HZ / PRIM_FAIL_HZ;
   typedef enum logic [1:0] {LOCK_IDLE, LOCK_GOT_FIRST, LOCK_OPEN} lock_state_t;
endpackage : osc_ctl_pkg

/* File: tb/osc_ctl_asserts.sv */
// Concurrent checks on the oscillator control block ports
`timescale 1ns/100ps
`default_nettype none
module osc_ctl_asserts
   import osc_ctl_pkg::*;
#(
   parameter int PRIM_FAIL_LIMIT = PRIM_FAIL_CYCLES,
   parameter int WDOG_HUNT_LIMIT = WDOG_HUNT_CYCLES
) (
   input wire logic CLK_SYS,
   input wire logic RESET,
   input wire logic [11:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [7:0] RDATA,
   input wire logic INT_FAST_TICK,
   input wire logic INT_SLOW_TICK,
   input wire logic EXT_CLOCK_PIN,
   input wire logic WDOG_OSC_TICK,
   input wire logic SYS_CLK_TICK,
   input wire logic INTERNAL_OSC_ENABLE,
   input wire logic WDOG_OSC_ENABLE,
   input wire logic PRIM_FAIL_EVENT,
   input wire logic WDOG_FAIL_EVENT,
   input wire logic [2:0] ACTIVE_SOURCE,
   input wire logic HALTED
);
   int idle_cnt_ff;
   int hunt_cnt_ff;
   logic wd_q_ff;
   logic wd_failed_ff;
   ////////////////////////////////////////////////////////////////
   // Helper counters; they run freely, so they only bound from below
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) idle_cnt_ff <= 0;
      else idle_cnt_ff <= SYS_CLK_TICK ? 0 : idle_cnt_ff + 1;
   end
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) wd_q_ff <= 1'b0;
      else wd_q_ff <= WDOG_OSC_TICK;
   end
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) hunt_cnt_ff <= 0;
      else if (WDOG_OSC_TICK && !wd_q_ff) hunt_cnt_ff <= 0;
      else if (SYS_CLK_TICK) hunt_cnt_ff <= hunt_cnt_ff + 1;
   end
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) wd_failed_ff <= 1'b0;
      else if (WDOG_FAIL_EVENT) wd_failed_ff <= 1'b1;
   end
   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RESET);
   rsvd_read_zero_a: assert property ($past(RD) |-> !RDATA[RSVD_BIT])
      else $error("reserved bit read back as one");
   enables_hold_a: assert property ($changed({INTERNAL_OSC_ENABLE, WDOG_OSC_ENABLE}) |-> $past(WR) || $past(WR, 2))
      else $error("oscillator enable changed without a write");
   prim_pulse_a: assert property (PRIM_FAIL_EVENT |=> !PRIM_FAIL_EVENT)
      else $error("primary failure event longer than one cycle");
   prim_switch_a: assert property (PRIM_FAIL_EVENT && WDOG_OSC_ENABLE && ACTIVE_SOURCE != SEL_WDOG
      |-> ##[1:200] ACTIVE_SOURCE == SEL_WDOG) else $error("no recovery to watchdog source");
   prim_noswitch_a: assert property (PRIM_FAIL_EVENT && !WDOG_OSC_ENABLE |=> (ACTIVE_SOURCE != SEL_WDOG) [*8])
      else $error("recovery to a disabled watchdog source");
   prim_timing_a: assert property (PRIM_FAIL_EVENT |-> idle_cnt_ff >= PRIM_FAIL_LIMIT)
      else $error("primary failure flagged too early");
   wdog_only_event_a: assert property (WDOG_FAIL_EVENT |=> !WDOG_FAIL_EVENT ##0 $stable(ACTIVE_SOURCE) [*4])
      else $error("watchdog failure moved the source or pulse too long");
   wdog_blocks_prim_a: assert property (wd_failed_ff |-> !PRIM_FAIL_EVENT)
      else $error("primary detection after watchdog failure");
   wdog_timing_a: assert property (WDOG_FAIL_EVENT |-> hunt_cnt_ff >= WDOG_HUNT_LIMIT - 2)
      else $error("watchdog failure flagged too early");
   halt_quiet_a: assert property (HALTED |-> !SYS_CLK_TICK)
      else $error("system tick while halted");
   prim_fail_c: cover property (PRIM_FAIL_EVENT);
   wdog_fail_c: cover property (WDOG_FAIL_EVENT);
   wdog_src_c: cover property (ACTIVE_SOURCE == SEL_WDOG);
endmodule : osc_ctl_asserts
bind osc_ctl osc_ctl_asserts #(.PRIM_FAIL_LIMIT(PRIM_FAIL_LIMIT), .WDOG_HUNT_LIMIT(WDOG_HUNT_LIMIT)) chk_i (
   .CLK_SYS(CLK_SYS), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
   .INT_FAST_TICK(INT_FAST_TICK), .INT_SLOW_TICK(INT_SLOW_TICK), .EXT_CLOCK_PIN(EXT_CLOCK_PIN),
   .WDOG_OSC_TICK(WDOG_OSC_TICK), .SYS_CLK_TICK(SYS_CLK_TICK), .INTERNAL_OSC_ENABLE(INTERNAL_OSC_ENABLE),
   .WDOG_OSC_ENABLE(WDOG_OSC_ENABLE), .PRIM_FAIL_EVENT(PRIM_FAIL_EVENT), .WDOG_FAIL_EVENT(WDOG_FAIL_EVENT),
   .ACTIVE_SOURCE(ACTIVE_SOURCE), .HALTED(HALTED));
`default_nettype wire

/* File: tb/osc_ctl_bench.sv */
// Register-level testbench for the oscillator control block
`timescale 1ns/100ps
`default_nettype none
module osc_ctl_bench;
   import osc_ctl_pkg::*;
   localparam int LIM = 50;
   localparam int HUNT = 20;
   logic clk_sys;
   logic reset;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic fast_tick = 1'b0;
   logic slow_tick = 1'b0;
   logic ext_pin = 1'b0;
   logic wdog_tick = 1'b0;
   logic fast_run = 1'b1;
   logic ext_run = 1'b1;
   logic wdog_run = 1'b1;
   logic int_en, wdog_en, prim_ev, wdog_ev, halted, sys_tick;
   logic [11:0] addr = 12'h000;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic [2:0] src;
   int cyc = 0;
   int prim_n = 0;
   int wdog_n = 0;
   int tick_n = 0;
   int t0 = 0;
   int n_fail = 0;
   int compares = 0;
   logic [7:0] bad [6] = '{8'h55, 8'h18, 8'he7, 8'h12, 8'h18, 8'h33};
   osc_ctl #(.PRIM_FAIL_LIMIT(LIM), .WDOG_HUNT_LIMIT(HUNT)) DUT (
      .CLK_SYS(clk_sys), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
      .INT_FAST_TICK(fast_tick), .INT_SLOW_TICK(slow_tick), .EXT_CLOCK_PIN(ext_pin), .WDOG_OSC_TICK(wdog_tick),
      .SYS_CLK_TICK(sys_tick), .INTERNAL_OSC_ENABLE(int_en), .WDOG_OSC_ENABLE(wdog_en), .PRIM_FAIL_EVENT(prim_ev),
      .WDOG_FAIL_EVENT(wdog_ev), .ACTIVE_SOURCE(src), .HALTED(halted));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////////////////////////////
   // Oscillator stand-ins; a disabled oscillator stops ticking
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      fast_tick <= fast_run && int_en && (cyc % 4 == 0);
      slow_tick <= int_en && (cyc % 16 == 0);
      if (cyc % 3 == 0) ext_pin <= ext_run && !ext_pin;
      if (cyc % 5 == 0) wdog_tick <= wdog_run && wdog_en && !wdog_tick;
      prim_n <= prim_n + int'(prim_ev === 1'b1);
      wdog_n <= wdog_n + int'(wdog_ev === 1'b1);
      tick_n <= tick_n + int'(sys_tick === 1'b1);
   end
   ////////////////////////////////////////////////////////////////
   task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk_sys);
      wr_s <= 1'b0;
   endtask : wr
   task rd(input logic [11:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk_sys);
      rd_s <= 1'b0;
      #1 chk("read data", rdata, exp);
   endtask : rd
   // Full unlock then one update
   task uw(input logic [7:0] d);
      wr(OSC_CTL_ADDR, UNLOCK_KEY_FIRST);
      wr(OSC_CTL_ADDR, UNLOCK_KEY_SECOND);
      wr(OSC_CTL_ADDR, d);
   endtask : uw
   task wait_src(input logic [2:0] s);
      for (int i = 0; i < 300 && src !== s; i++) @(posedge clk_sys);
      chk("active source", {5'h0, src}, {5'h0, s});
   endtask : wait_src
   task report_and_stop;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop
   initial begin
      #100us;
      n_fail++;
      report_and_stop();
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      reset = 1'b1;
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      rd(OSC_CTL_ADDR, OSC_CTL_RESET);
      chk("enables", {6'h0, int_en, wdog_en}, 8'h03);
      // Wrong orders and stray values never open the register
      foreach (bad[i]) wr(OSC_CTL_ADDR, bad[i]);
      rd(OSC_CTL_ADDR, OSC_CTL_RESET);
      wr(OSC_CTL_ADDR, UNLOCK_KEY_FIRST);
      wr(12'h010, 8'h77);
      rd(12'h010, 8'h00);
      wr(OSC_CTL_ADDR, UNLOCK_KEY_SECOND);
      wr(OSC_CTL_ADDR, 8'he1);
      rd(OSC_CTL_ADDR, 8'ha1);
      wr(OSC_CTL_ADDR, 8'h22);
      rd(OSC_CTL_ADDR, 8'ha1);
      // Detectors off and every source running before each switch
      for (int s = 0; s < 4; s++) begin
         uw(8'ha0 | 8'(s));
         wait_src(3'(s));
      end
      chk("int osc kept", {7'h0, int_en}, 8'h01);
      uw(8'h22);
      wait_src(SEL_EXT);
      chk("enables", {6'h0, int_en, wdog_en}, 8'h01);
      // External clock dies with recovery available
      uw(8'h32);
      ext_run <= 1'b0;
      repeat (LIM + 100) @(posedge clk_sys);
      chk("primary events", 8'(prim_n), 8'h01);
      wait_src(SEL_WDOG);
      ext_run <= 1'b1;
      uw(8'h22);
      wait_src(SEL_EXT);
      // Same failure with the watchdog oscillator off
      uw(8'h12);
      ext_run <= 1'b0;
      repeat (LIM + 100) @(posedge clk_sys);
      chk("primary events", 8'(prim_n), 8'h02);
      chk("active source", {5'h0, src}, {5'h0, SEL_EXT});
      uw(8'h00);
      t0 = tick_n;
      repeat (50) @(posedge clk_sys);
      chk("halted", {7'h0, halted}, 8'h01);
      chk("halted ticks", 8'(tick_n - t0), 8'h00);
      ext_run <= 1'b1;
      reset <= 1'b1;
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      rd(OSC_CTL_ADDR, OSC_CTL_RESET);
      wait_src(SEL_INT_FAST);
      // Fast stand-in ticks every fourth cycle
      t0 = tick_n;
      repeat (40) @(posedge clk_sys);
      chk("fast ticks", 8'(tick_n - t0), 8'h0a);
      // Unused select codes fall back to the fast internal source
      uw(8'ha4);
      rd(OSC_CTL_ADDR, 8'ha4);
      chk("active source", {5'h0, src}, {5'h0, SEL_INT_FAST});
      // Watchdog oscillator stops while both detectors are armed
      uw(8'hb8);
      wdog_run <= 1'b0;
      repeat (4 * HUNT + 100) @(posedge clk_sys);
      chk("watchdog events", 8'(wdog_n), 8'h01);
      chk("active source", {5'h0, src}, {5'h0, SEL_INT_FAST});
      fast_run <= 1'b0;
      repeat (LIM + 100) @(posedge clk_sys);
      chk("primary events", 8'(prim_n), 8'h02);
      report_and_stop();
   end
endmodule : osc_ctl_bench
`default_nettype wire
